// >>> hw/ipf_core.sv
// instruction pointer, segment choice and status flag block
// assumes core event inputs are one-cycle pulses synchronous to clock
//
// Local design decisions: the address map and the Wishbone interface to the registers.
`timescale 1ns/10ps
module ipf_core
  import ipf_pkg::*;
#(
  parameter int DATA_W = 32,
  parameter int LEN_W = 4,
  parameter logic [31:0] IP_RESET = 32'h0000_0000
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [3:0] adr_i,
  input wire logic [DATA_W-1:0] dat_i,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic [DATA_W-1:0] dat_o,
  output logic ack_o,
  input wire logic retire_valid,
  input wire logic [LEN_W-1:0] retire_len,
  input wire logic redirect_valid,
  input wire logic [31:0] redirect_target,
  input wire logic ref_valid,
  input wire ref_type ref_kind,
  input wire logic override_valid,
  input wire seg_type override_seg,
  input wire logic alu_valid,
  input wire logic alu_sub,
  input wire logic [31:0] alu_a,
  input wire logic [31:0] alu_b,
  input wire logic pop_valid,
  input wire logic pop_is_iret,
  input wire logic [31:0] pop_value,
  input wire logic task_switch_valid,
  input wire logic [31:0] task_flags,
  input wire logic maskable_irq_pin,
  input wire logic debug_hit,
  input wire logic misaligned,
  input wire logic io_request,
  input wire logic priv_opcode,
  output logic [31:0] next_instr_offset,
  output logic [31:0] processor_status_flags,
  output seg_type seg_select,
  output logic irq_take,
  output logic step_trap,
  output logic debug_fault,
  output logic align_fault,
  output logic io_bitmap_check,
  output logic gp_fault,
  output logic index_decrement,
  output logic nested_task,
  output logic v86_active
);
  // -------------------------------------------------------------
  // parameter checks
  // -------------------------------------------------------------
  if (DATA_W != 32) begin : g_bad_width
    $error("ipf_core serves only a 32-bit data bus");
  end
  if (LEN_W < 1 || LEN_W > 8) begin : g_bad_len
    $error("ipf_core instruction length width must be 1 to 8");
  end

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  typedef struct packed {
    bus_state_type bus;
    logic ack;
    logic [31:0] rdata;
    logic [31:0] ip;
    logic [31:0] flags;
    logic [7:0] ctrl;
    seg_type seg;
    logic irq;
    logic step;
    logic dbg;
    logic align;
    logic bitmap;
    logic gp;
    logic idx_dec;
    logic nest;
    logic v86;
  } state_type;

  state_type s_reg;
  state_type s_next;
  flag_calc_if fc();
  logic bus_wr;
  logic pmode;
  logic priv_ok;
  logic [1:0] current_privilege;
  logic [1:0] io_privilege_level;
  logic [31:0] keep;

  // byte-lane merge of a bus write into an existing word
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // flag load: bits in keep hold old value, reserved bits forced
  function automatic logic [31:0] flag_load(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [31:0] kp);
    logic [31:0] r;
    r = (nw & ~kp) | (old & kp);
    return (r & ~RSVD_ZERO_MASK) | RSVD_ONE_MASK;
  endfunction

  // segment for a reference; fixed kinds ignore the override
  function automatic seg_type seg_pick(input ref_type k, input logic ov,
                                       input seg_type os);
    seg_type r;
    r = SEG_DATA;
    unique case (k)
      REF_FETCH: r = SEG_CODE;
      REF_PUSH: r = SEG_STACK;
      REF_POP: r = SEG_STACK;
      REF_STR_DEST: r = SEG_EXTRA;
      REF_DATA: r = (ov && os != SEG_DATA) ? os : SEG_DATA;
      REF_DATA_SBASE: r = (ov && os != SEG_STACK) ? os : SEG_STACK;
      default: r = SEG_DATA;
    endcase
    return r;
  endfunction

  // -------------------------------------------------------------
  // arithmetic flag calculator
  // -------------------------------------------------------------
  assign fc.a = alu_a;
  assign fc.b = alu_b;
  assign fc.sub = alu_sub;
  flag_calc u_calc (
    .fc(fc.calc)
  );

  // privilege view shared by several decisions
  assign pmode = s_reg.ctrl[CTL_PMODE_POS];
  assign current_privilege = s_reg.ctrl[CTL_CPL_HI:CTL_CPL_LO];
  assign io_privilege_level = s_reg.flags[PRIV_HI_POS:PRIV_LO_POS];
  assign priv_ok = (current_privilege <= io_privilege_level);
  // write lands on the edge at which the master sees ack
  assign bus_wr = s_reg.ack && cyc_i && stb_i && we_i;
  // probe bit is frozen unless software enabled it
  assign keep = s_reg.ctrl[CTL_PROBE_EN_POS] ? 32'h0000_0000 : (32'h1 << PROBE_POS);

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb begin
    logic [31:0] kp;
    logic [31:0] f;
    kp = 32'h0000_0000;
    f = 32'h0000_0000;
    s_next = s_reg;
    s_next.ack = 1'b0;
    // bus slave: one wait state, ack for exactly one cycle
    unique case (s_reg.bus)
      BUS_IDLE: begin
        if (cyc_i && stb_i) begin
          s_next.bus = BUS_ACK;
          s_next.ack = 1'b1;
          unique case (adr_i)
            OFS_IP: s_next.rdata = s_reg.ip;
            OFS_FLAGS: s_next.rdata = s_reg.flags;
            OFS_CTRL: s_next.rdata = {24'h00_0000, s_reg.ctrl};
            OFS_STAT: s_next.rdata = {23'h00_0000, s_reg.v86, s_reg.nest, s_reg.idx_dec,
                                      s_reg.gp, s_reg.bitmap, s_reg.align, s_reg.dbg,
                                      s_reg.step, s_reg.irq};
            default: s_next.rdata = 32'h0000_0000;
          endcase
        end
      end
      BUS_ACK: begin
        s_next.bus = BUS_IDLE;
      end
    endcase
    // software writes; v86 bit is not writable from the bus
    if (bus_wr) begin
      unique case (adr_i)
        OFS_IP: s_next.ip = lane_merge(s_reg.ip, dat_i, sel_i);
        OFS_FLAGS: s_next.flags = flag_load(s_reg.flags,
                                            lane_merge(s_reg.flags, dat_i, sel_i),
                                            keep | (32'h1 << V86_POS));
        OFS_CTRL: s_next.ctrl = sel_i[0] ? dat_i[7:0] : s_reg.ctrl; // control lives in lane 0
        default: s_next.ctrl = s_reg.ctrl;
      endcase
    end
    // popped flags: interrupt enable and v86 guarded by privilege
    if (pop_valid) begin
      kp = keep;
      if (!priv_ok) begin
        kp[IRQ_EN_POS] = 1'b1;
      end
      if (!(pop_is_iret && current_privilege == PRIV_TOP)) begin
        kp[V86_POS] = 1'b1;
      end
      s_next.flags = flag_load(s_reg.flags, pop_value, kp);
    end
    // a task switch reloads flags at any privilege
    if (task_switch_valid) begin
      s_next.flags = flag_load(s_reg.flags, task_flags, keep);
    end
    // core events win over a same-cycle bus write
    if (alu_valid) begin
      f = s_next.flags;
      f[CARRY_POS] = fc.carry;
      f[PARITY_POS] = fc.parity;
      f[NIBBLE_POS] = fc.nibble;
      f[ZERO_POS] = fc.zero;
      f[SIGN_POS] = fc.sign;
      f[OVF_POS] = fc.ovf;
      s_next.flags = f;
    end
    // pointer: redirect beats sequential advance, both beat the bus
    if (redirect_valid) begin
      s_next.ip = redirect_target;
    end else if (retire_valid) begin
      s_next.ip = s_reg.ip + {{(32-LEN_W){1'b0}}, retire_len};
    end
    // single step fires once the instruction completes and clears itself
    s_next.step = retire_valid && s_reg.flags[STEP_POS];
    if (retire_valid) begin
      s_next.flags[STEP_POS] = 1'b0;
      s_next.flags[RESUME_POS] = 1'b0; // resume covers one instruction only
    end
    // segment selection for the reference presented this cycle
    if (ref_valid) begin
      s_next.seg = seg_pick(ref_kind, override_valid, override_seg);
    end
    // per-cycle event outputs
    s_next.irq = maskable_irq_pin && s_reg.flags[IRQ_EN_POS];
    s_next.dbg = debug_hit && !s_reg.flags[RESUME_POS];
    s_next.align = misaligned && s_reg.flags[ALIGN_POS]
                   && s_reg.ctrl[CTL_AMASK_POS];
    s_next.bitmap = io_request && pmode && !priv_ok;
    s_next.gp = priv_opcode && pmode && s_reg.flags[V86_POS];
    s_next.idx_dec = s_next.flags[DIR_POS];
    s_next.nest = pmode && s_next.flags[NEST_POS];
    s_next.v86 = pmode && s_next.flags[V86_POS];
  end

  // -------------------------------------------------------------
  // state register
  // -------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_reg <= '0;
      s_reg.ip <= IP_RESET;
      s_reg.flags <= FLAGS_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register
  assign dat_o = s_reg.rdata;
  assign ack_o = s_reg.ack;
  assign next_instr_offset = s_reg.ip;
  assign processor_status_flags = s_reg.flags;
  assign seg_select = s_reg.seg;
  assign irq_take = s_reg.irq;
  assign step_trap = s_reg.step;
  assign debug_fault = s_reg.dbg;
  assign align_fault = s_reg.align;
  assign io_bitmap_check = s_reg.bitmap;
  assign gp_fault = s_reg.gp;
  assign index_decrement = s_reg.idx_dec;
  assign nested_task = s_reg.nest;
  assign v86_active = s_reg.v86;

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  sequence seq_step_retire;
    retire_valid && s_reg.flags[STEP_POS];
  endsequence
  sequence seq_step_taken;
    step_trap && !processor_status_flags[STEP_POS];
  endsequence

  AST_RSVD: assert property (
    (processor_status_flags & RSVD_ZERO_MASK) == 32'h0 && processor_status_flags[1]
  ) else $error("reserved flag bits not at fixed values");
  AST_IP_ADV: assert property (
    retire_valid && !redirect_valid |=> next_instr_offset ==
      $past(next_instr_offset) + {{(32-LEN_W){1'b0}}, $past(retire_len)}
  ) else $error("pointer did not advance by instruction length");
  AST_IP_JUMP: assert property (
    redirect_valid |=> next_instr_offset == $past(redirect_target)
  ) else $error("pointer did not take redirect target");
  AST_FETCH: assert property (
    ref_valid && ref_kind == REF_FETCH |=> seg_select == SEG_CODE
  ) else $error("fetch not on code segment");
  AST_STACK: assert property (
    ref_valid && (ref_kind == REF_PUSH || ref_kind == REF_POP) |=> seg_select == SEG_STACK
  ) else $error("stack reference not on stack segment");
  AST_STRDST: assert property (
    ref_valid && ref_kind == REF_STR_DEST |=> seg_select == SEG_EXTRA
  ) else $error("string destination not on extra segment");
  AST_PROBE: assert property (
    !s_reg.ctrl[CTL_PROBE_EN_POS] |=> $stable(processor_status_flags[PROBE_POS])
  ) else $error("probe bit changed while locked");
  AST_STEP: assert property (
    seq_step_retire |=> seq_step_taken
  ) else $error("single step not taken or trap flag not cleared");
  AST_IRQ: assert property (
    irq_take |-> $past(maskable_irq_pin) && $past(processor_status_flags[IRQ_EN_POS])
  ) else $error("interrupt taken while disabled");
  AST_RESUME: assert property (
    debug_hit && processor_status_flags[RESUME_POS] |=> !debug_fault
  ) else $error("debug fault raised with resume flag set");
  AST_ALIGN: assert property (
    align_fault |-> $past(processor_status_flags[ALIGN_POS] && s_reg.ctrl[CTL_AMASK_POS])
  ) else $error("alignment fault without both enables");
  AST_ZERO: assert property (
    alu_valid && alu_sub && alu_a == alu_b |=> processor_status_flags[ZERO_POS]
  ) else $error("zero flag clear after equal subtract");
  AST_ACK: assert property (
    ack_o |=> !ack_o
  ) else $error("ack held more than one cycle");
endmodule

// >>> inc/ipf_pkg.sv
// constants for the instruction pointer and status flag block
// assumes a 32-bit classic wishbone slave and a core that reports events
package ipf_pkg;
  // -------------------------------------------------------------
  // flag bit positions
  // -------------------------------------------------------------
  localparam int CARRY_POS = 0;
  localparam int PARITY_POS = 2;
  localparam int NIBBLE_POS = 4;
  localparam int ZERO_POS = 6;
  localparam int SIGN_POS = 7;
  localparam int STEP_POS = 8;
  localparam int IRQ_EN_POS = 9;
  localparam int DIR_POS = 10;
  localparam int OVF_POS = 11;
  localparam int PRIV_LO_POS = 12;
  localparam int PRIV_HI_POS = 13;
  localparam int NEST_POS = 14;
  localparam int RESUME_POS = 16;
  localparam int V86_POS = 17;
  localparam int ALIGN_POS = 18;
  localparam int PROBE_POS = 21;
  localparam logic [31:0] RSVD_ZERO_MASK = 32'hFFD8_8028;
  localparam logic [31:0] RSVD_ONE_MASK = 32'h0000_0002;
  localparam logic [31:0] FLAGS_RESET = 32'h0000_0002;
  // -------------------------------------------------------------
  // register map (byte addresses) and control fields
  // -------------------------------------------------------------
  localparam logic [3:0] OFS_IP = 4'h0;
  localparam logic [3:0] OFS_FLAGS = 4'h4;
  localparam logic [3:0] OFS_CTRL = 4'h8;
  localparam logic [3:0] OFS_STAT = 4'hC;
  localparam int CTL_PMODE_POS = 0;
  localparam int CTL_CPL_LO = 1;
  localparam int CTL_CPL_HI = 2;
  localparam int CTL_AMASK_POS = 3;
  localparam int CTL_PROBE_EN_POS = 7;
  localparam logic [1:0] PRIV_TOP = 2'h0;
  // -------------------------------------------------------------
  // enumerations
  // -------------------------------------------------------------
  typedef enum logic [2:0] {
    SEG_EXTRA = 3'b000,
    SEG_CODE = 3'b001,
    SEG_STACK = 3'b010,
    SEG_DATA = 3'b011,
    SEG_XTRA2 = 3'b100,
    SEG_XTRA3 = 3'b101
  } seg_type;
  typedef enum logic [2:0] {
    REF_FETCH = 3'b000,
    REF_PUSH = 3'b001,
    REF_POP = 3'b010,
    REF_STR_DEST = 3'b011,
    REF_DATA = 3'b100,
    REF_DATA_SBASE = 3'b101
  } ref_type;
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } bus_state_type;
endpackage

// >>> inc/flag_calc_if.sv
// carrier between the flag block and its arithmetic flag calculator
// assumes both ends share one clock domain; contents are combinational
`timescale 1ns/10ps
interface flag_calc_if;
  logic [31:0] a;
  logic [31:0] b;
  logic sub;
  logic [31:0] res;
  logic carry;
  logic parity;
  logic nibble;
  logic zero;
  logic sign;
  logic ovf;
  modport calc(input a, b, sub, output res, carry, parity, nibble, zero, sign, ovf);
  modport user(output a, b, sub, input res, carry, parity, nibble, zero, sign, ovf);
endinterface

// >>> hw/flag_calc.sv
// arithmetic flag calculator for 32-bit add and subtract
// assumes operands are stable for the cycle in which the result is used
`timescale 1ns/10ps
module flag_calc
  import ipf_pkg::*;
(
  flag_calc_if.calc fc
);
  logic [32:0] sum;
  logic [31:0] opb;
  // -------------------------------------------------------------
  // add, or subtract as a plus inverted b plus one
  // -------------------------------------------------------------
  always_comb begin
    opb = fc.sub ? ~fc.b : fc.b;
    sum = {1'b0, fc.a} + {1'b0, opb} + {32'h0000_0000, fc.sub};
    fc.res = sum[31:0];
    fc.carry = sum[32] ^ fc.sub; // borrow is inverted carry
    fc.ovf = (fc.a[31] ^ opb[31] ^ sum[31]) ^ sum[32];
    fc.nibble = fc.a[4] ^ fc.b[4] ^ sum[4]; // carry or borrow at bit 3
    fc.zero = (sum[31:0] == 32'h0000_0000);
    fc.sign = sum[31];
    fc.parity = ~^sum[7:0]; // even count of ones
  end
endmodule

// >>> hw/unused_placeholder_none.sv
// intentionally empty: the block is the flag core and its calculator only
// assumes nothing; kept so that the file list stays stable

// >>> tb/tb_ipf_core.sv
// self-checking bench for the instruction pointer and status flag block
// assumes the package, carrier interface and design files are compiled first
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb_ipf_core
  import ipf_pkg::*;
;
  logic clock, reset_n, we_i, cyc_i, stb_i, ack_o;
  logic [3:0] adr_i, sel_i, retire_len;
  logic [31:0] dat_i, dat_o, redirect_target, alu_a, alu_b, pop_value, task_flags;
  logic retire_valid, redirect_valid, ref_valid, override_valid, alu_valid, alu_sub;
  logic pop_valid, pop_is_iret, task_switch_valid, maskable_irq_pin, debug_hit;
  logic misaligned, io_request, priv_opcode, irq_take, step_trap, debug_fault;
  logic align_fault, io_bitmap_check, gp_fault, index_decrement, nested_task, v86_active;
  logic [31:0] next_instr_offset, processor_status_flags, q, ip, e;
  ref_type ref_kind;
  seg_type override_seg, seg_select;
  int num_errors = 0;
  int n_tests = 0;
  integer seed = 32'h1C71;
  ipf_core DUT (.clock(clock), .reset_n(reset_n), .adr_i(adr_i), .dat_i(dat_i),
    .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o),
    .ack_o(ack_o), .retire_valid(retire_valid), .retire_len(retire_len),
    .redirect_valid(redirect_valid), .redirect_target(redirect_target),
    .ref_valid(ref_valid), .ref_kind(ref_kind), .override_valid(override_valid),
    .override_seg(override_seg), .alu_valid(alu_valid), .alu_sub(alu_sub),
    .alu_a(alu_a), .alu_b(alu_b), .pop_valid(pop_valid), .pop_is_iret(pop_is_iret),
    .pop_value(pop_value), .task_switch_valid(task_switch_valid),
    .task_flags(task_flags), .maskable_irq_pin(maskable_irq_pin),
    .debug_hit(debug_hit), .misaligned(misaligned), .io_request(io_request),
    .priv_opcode(priv_opcode), .next_instr_offset(next_instr_offset),
    .processor_status_flags(processor_status_flags), .seg_select(seg_select),
    .irq_take(irq_take), .step_trap(step_trap), .debug_fault(debug_fault),
    .align_fault(align_fault), .io_bitmap_check(io_bitmap_check),
    .gp_fault(gp_fault), .index_decrement(index_decrement),
    .nested_task(nested_task), .v86_active(v86_active));
  // -------------------------------------------------------------
  // clock, closing report
  // -------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task conclude;
    if (num_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // -------------------------------------------------------------
  // bus cycle and expectation helpers
  // -------------------------------------------------------------
  // one classic cycle; the request stands until ack is sampled high
  task wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    adr_i <= a; we_i <= w; dat_i <= d; sel_i <= 4'hF; cyc_i <= 1'b1; stb_i <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    q = dat_o;
    cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      conclude();
    end
  endtask
  // waits out the edge that samples a pulse, then lets its updates land
  task settle;
    @(posedge clock);
    #1;
  endtask
  function automatic seg_type exp_seg(ref_type k, logic ov, seg_type os);
    case (k)
      REF_FETCH: return SEG_CODE;
      REF_PUSH, REF_POP: return SEG_STACK;
      REF_STR_DEST: return SEG_EXTRA;
      REF_DATA: return ov ? os : SEG_DATA;
      default: return ov ? os : SEG_STACK;
    endcase
  endfunction
  function automatic logic [31:0] exp_alu(logic [31:0] a, logic [31:0] b, logic s);
    logic [32:0] w;
    logic [4:0] nb;
    logic [31:0] f;
    w = s ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
    nb = s ? {1'b0, a[3:0]} - {1'b0, b[3:0]} : {1'b0, a[3:0]} + {1'b0, b[3:0]};
    f = 32'h0000_0000;
    f[CARRY_POS] = w[32];
    f[PARITY_POS] = ~^w[7:0];
    f[NIBBLE_POS] = nb[4];
    f[ZERO_POS] = (w[31:0] == 32'h0000_0000);
    f[SIGN_POS] = w[31];
    f[OVF_POS] = ((a[31] ^ b[31]) == s) && (w[31] != a[31]);
    return f;
  endfunction
  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    {we_i, cyc_i, stb_i, retire_valid, redirect_valid, ref_valid, override_valid} = '0;
    {alu_valid, alu_sub, pop_valid, pop_is_iret, task_switch_valid} = '0;
    {maskable_irq_pin, debug_hit, misaligned, io_request, priv_opcode} = '0;
    {adr_i, sel_i, retire_len, dat_i, redirect_target, alu_a, alu_b} = '0;
    {pop_value, task_flags} = '0;
    ref_kind = REF_FETCH;
    override_seg = SEG_EXTRA;
    reset_n = 1'b0;
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    #1 `CHK("reset flags", 32'h0000_0002, processor_status_flags)
    `CHK("reset ip", 32'h0000_0000, next_instr_offset)
    wb(4'h2, 1'b0, 32'h0);
    `CHK("unmapped read", 32'h0000_0000, q)
    // all ones: reserved forced, probe and v86 guarded
    wb(OFS_FLAGS, 1'b1, 32'hFFFF_FFFF);
    wb(OFS_FLAGS, 1'b0, 32'h0);
    e = (~RSVD_ZERO_MASK | RSVD_ONE_MASK) & ~(32'h1 << PROBE_POS) & ~(32'h1 << V86_POS);
    `CHK("flags after ones", e, q)
    `CHK("index decrement", 1'b1, index_decrement)
    @(posedge clock); maskable_irq_pin <= 1'b1; debug_hit <= 1'b1;
    @(posedge clock); debug_hit <= 1'b0; #1;
    `CHK("irq taken", 1'b1, irq_take)
    `CHK("debug suppressed", 1'b0, debug_fault)
    ip = next_instr_offset;
    @(posedge clock); retire_valid <= 1'b1; retire_len <= 4'h3;
    @(posedge clock); retire_valid <= 1'b0; #1;
    `CHK("ip step", ip + 32'h3, next_instr_offset)
    `CHK("step trap", 1'b1, step_trap)
    `CHK("trap cleared", 1'b0, processor_status_flags[STEP_POS])
    @(posedge clock); debug_hit <= 1'b1;
    @(posedge clock); debug_hit <= 1'b0; #1;
    `CHK("debug after resume", 1'b1, debug_fault)
    // alignment mask and probe enable in the control word
    wb(OFS_CTRL, 1'b1, 32'h0000_0088);
    @(posedge clock); misaligned <= 1'b1;
    @(posedge clock); misaligned <= 1'b0; #1;
    `CHK("align fault", 1'b1, align_fault)
    wb(OFS_FLAGS, 1'b1, 32'hFFFF_FFFF);
    settle();
    `CHK("probe writable", 1'b1, processor_status_flags[PROBE_POS])
    wb(OFS_FLAGS, 1'b1, 32'h0);
    settle();
    `CHK("flags zero write", 32'h0000_0002, processor_status_flags)
    `CHK("index increment", 1'b0, index_decrement)
    settle();
    `CHK("irq masked", 1'b0, irq_take)
    maskable_irq_pin <= 1'b0;
    // protected mode, privilege 3, i/o level 0
    wb(OFS_CTRL, 1'b1, 32'h0000_0007);
    @(posedge clock); pop_valid <= 1'b1; pop_value <= 32'hFFFF_FFFF; io_request <= 1'b1;
    @(posedge clock); pop_valid <= 1'b0; io_request <= 1'b0; #1;
    `CHK("pop keeps irq enable", 1'b0, processor_status_flags[IRQ_EN_POS])
    `CHK("pop keeps v86", 1'b0, processor_status_flags[V86_POS])
    `CHK("io check", 1'b1, io_bitmap_check)
    @(posedge clock); task_switch_valid <= 1'b1;
    task_flags <= (32'h1 << V86_POS) | (32'h1 << NEST_POS) | 32'h2;
    @(posedge clock); task_switch_valid <= 1'b0; priv_opcode <= 1'b1; #1;
    settle();
    priv_opcode <= 1'b0;
    `CHK("v86 active", 1'b1, v86_active)
    `CHK("nested task", 1'b1, nested_task)
    `CHK("gp fault", 1'b1, gp_fault)
    wb(OFS_CTRL, 1'b1, 32'h0);
    settle();
    settle();
    `CHK("nested real mode", 1'b0, nested_task)
    `CHK("v86 real mode", 1'b0, v86_active)
    // interrupt return at privilege 0 may change both guarded bits
    @(posedge clock); pop_valid <= 1'b1; pop_is_iret <= 1'b1;
    pop_value <= (32'h1 << IRQ_EN_POS) | 32'h0000_0002;
    @(posedge clock); pop_valid <= 1'b0; pop_is_iret <= 1'b0; #1;
    `CHK("iret sets irq enable", 1'b1, processor_status_flags[IRQ_EN_POS])
    `CHK("iret clears v86", 1'b0, processor_status_flags[V86_POS])
    // flow change then random sequential retires
    @(posedge clock); redirect_valid <= 1'b1; redirect_target <= $random(seed);
    @(posedge clock); redirect_valid <= 1'b0; #1;
    `CHK("redirect", redirect_target, next_instr_offset)
    for (int i = 0; i < 12; i++) begin
      ip = next_instr_offset;
      @(posedge clock); retire_valid <= 1'b1; retire_len <= 4'($random(seed));
      @(posedge clock); retire_valid <= 1'b0; #1;
      `CHK("ip advance", ip + {28'h0, retire_len}, next_instr_offset)
    end
    // every reference kind with random overrides
    for (int i = 0; i < 36; i++) begin
      @(posedge clock); ref_valid <= 1'b1; ref_kind <= ref_type'(3'(i % 6));
      override_valid <= 1'($random(seed));
      override_seg <= seg_type'(3'(($random(seed) & 7) % 6));
      @(posedge clock); ref_valid <= 1'b0; #1;
      e = 32'(exp_seg(ref_kind, override_valid, override_seg));
      `CHK("segment", e[2:0], seg_select)
    end
    // arithmetic flags: corners first, then random operands
    for (int i = 0; i < 40; i++) begin
      @(posedge clock); alu_valid <= 1'b1;
      // corner 4 subtracts equal operands so the zero result is reached
      alu_a <= (i == 4) ? 32'h0000_0001 : (i < 4) ? 32'hFFFF_FFFF >> i[0] : $random(seed);
      alu_b <= (i < 5) ? 32'h0000_0001 : $random(seed);
      alu_sub <= (i == 4) ? 1'b1 : (i < 4) ? i[1] : 1'($random(seed));
      @(posedge clock); alu_valid <= 1'b0; #1;
      e = exp_alu(alu_a, alu_b, alu_sub);
      `CHK("alu flags", e, processor_status_flags & 32'h0000_08D5)
    end
    conclude();
  end
endmodule
